// ---- rtl/scpt_pkg.sv ----
// Constants for the system clock prescaler and oscillator trim block.
// Assumes one 50 MHz reference clock and an APB register slave.
package scpt_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int         REF_CLK_PERIOD_NS = 20;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int         ADDR_W            = 12;
    localparam logic [11:0] OFS_OSC_TRIM     = 12'h000;
    localparam logic [11:0] OFS_DIV_CTRL     = 12'h004;

    // ------------------------------------------------------------
    // Divider control field layout
    // ------------------------------------------------------------
    localparam int         CTL_CEN_BIT       = 7;
    localparam int         CTL_SEL_MSB       = 3;
    localparam int         SEL_W             = 4;
    localparam int         CNT_W             = 8;
    localparam logic [7:0] CTL_UNLOCK_VALUE  = 8'h80;

    // ------------------------------------------------------------
    // Division codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_MAX_LEGAL     = 4'h8;
    localparam logic [3:0] SEL_RST_PLAIN     = 4'h0;
    localparam logic [3:0] SEL_RST_DIV8      = 4'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [1:0] CEN_WINDOW_LAST   = 2'h3;

    typedef enum logic [1:0] {
        SCPT_BUS_IDLE,
        SCPT_BUS_WAIT,
        SCPT_BUS_DONE
    } scpt_bus_t;

endpackage : scpt_pkg

// ---- rtl/scpt_divider.sv ----
// Power-of-two divider that emits one tick per divided clock period.
// Assumes the select input is already limited to legal codes.
`timescale 1ns/1ps
module scpt_divider
    import scpt_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [SEL_W-1:0] rst_sel,
    input  wire logic [SEL_W-1:0] new_sel,
    input  wire logic             new_sel_vld,
    output logic                  tick,
    output logic [SEL_W-1:0]      active_sel
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [SEL_W-1:0] act_q;
    logic [SEL_W-1:0] act_d;
    logic [SEL_W-1:0] pend_q;
    logic [SEL_W-1:0] pend_d;
    logic             tick_q;
    logic             tick_d;
    logic [CNT_W-1:0] last_cnt;

    // ------------------------------------------------------------
    // Period length of the active setting
    // ------------------------------------------------------------
    always_comb begin
        last_cnt = CNT_W'((16'h0001 << act_q) - 16'h0001);
    end

    // ------------------------------------------------------------
    // Counter and switch-over
    // ------------------------------------------------------------
    always_comb begin
        cnt_d  = cnt_q + 8'h01;
        act_d  = act_q;
        pend_d = pend_q;
        tick_d = 1'b0;
        if (new_sel_vld) begin
            pend_d = new_sel;
        end
        // switch at boundary
        // New setting is only taken at the end of an old period, so no
        // period is ever shorter than both the old and the new one.
        if (cnt_q == last_cnt) begin
            cnt_d  = '0;
            tick_d = 1'b1;
            act_d  = new_sel_vld ? new_sel : pend_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            act_q  <= rst_sel;
            pend_q <= rst_sel;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            act_q  <= act_d;
            pend_q <= pend_d;
            tick_q <= tick_d;
        end
    end

    assign tick       = tick_q;
    assign active_sel = act_q;

endmodule : scpt_divider

// ---- rtl/scpt_top.sv ----
// System clock prescaler and RC oscillator trim control with APB access.
// Assumes an APB master on REF_CLK and strap inputs stable during reset.
//
// Function
// - Reset loads the factory calibration byte into the oscillator trim register.
// - Software may write the trim register any time; oscillator follows it.
// - Trim top bit picks low or high overlapping frequency range.
// - Low seven trim bits tune monotonically within the chosen range.
// - Change enable sets only when written one with all other bits zero.
// - Change enable clears four cycles after setting or on select write.
// - Rewriting change enable inside its window neither extends nor clears.
// - Select writes outside the open window are ignored.
// - Reset select is 0000, or 0011 when divide-by-eight fuse programmed.
// - Any select may be written after reset, whatever the fuse.
// - Select gives factor two to its power for 0-8; 9 up reserved.
// - Divided clock drives CPU and peripherals; changeable at run time.
// - Factor changes cause no glitch and no faster intermediate period.
// - New rate active within one old plus one or two new periods.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module scpt_top
    import scpt_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              RST_B,
    input  wire logic [7:0]        FACTORY_TRIM,
    input  wire logic              DIV8_FUSE,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    output logic [7:0]             OSC_TRIM,
    output logic                   SYS_CLK_TICK,
    output logic [SEL_W-1:0]       DIV_SEL_ACTIVE
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    scpt_bus_t        bus_q;
    scpt_bus_t        bus_d;
    logic [31:0]      rdata_q;
    logic [31:0]      rdata_d;
    logic             slverr_q;
    logic             slverr_d;

    logic [7:0]       trim_q;
    logic [7:0]       trim_d;
    logic [SEL_W-1:0] sel_q;
    logic [SEL_W-1:0] sel_d;
    logic             cen_q;
    logic             cen_d;
    logic [1:0]       cen_cnt_q;
    logic [1:0]       cen_cnt_d;

    logic             hit_trim;
    logic             hit_ctrl;
    logic             commit;
    logic             wr_trim;
    logic             wr_ctrl;
    logic [7:0]       wbyte;
    logic             wr_unlock;
    logic             wr_select;
    logic             sel_load;
    logic [SEL_W-1:0] sel_to_div;
    logic [SEL_W-1:0] sel_rst;
    logic [7:0]       ctrl_view;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        hit_trim = (PADDR == OFS_OSC_TRIM);
        hit_ctrl = (PADDR == OFS_DIV_CTRL);
        wbyte    = PWDATA[7:0];
    end

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    // One wait state lets read data and the error flag leave flops.
    always_comb begin
        bus_d    = bus_q;
        rdata_d  = rdata_q;
        slverr_d = slverr_q;
        commit   = 1'b0;
        unique case (bus_q)
            SCPT_BUS_IDLE: begin
                if (PSEL && PENABLE) begin
                    bus_d    = SCPT_BUS_WAIT;
                    slverr_d = !(hit_trim || hit_ctrl);
                    rdata_d  = '0;
                    if (!PWRITE && hit_trim) begin
                        rdata_d = {24'h000000, trim_q};
                    end
                    if (!PWRITE && hit_ctrl) begin
                        rdata_d = {24'h000000, ctrl_view};
                    end
                end
            end
            SCPT_BUS_WAIT: begin
                commit   = 1'b1;
                bus_d    = SCPT_BUS_DONE;
            end
            SCPT_BUS_DONE: begin
                bus_d    = SCPT_BUS_IDLE;
                slverr_d = 1'b0;
                rdata_d  = '0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            bus_q    <= SCPT_BUS_IDLE;
            rdata_q  <= '0;
            slverr_q <= 1'b0;
        end else begin
            bus_q    <= bus_d;
            rdata_q  <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    // Writes take effect only at the edge where PREADY is sampled high.
    always_comb begin
        wr_trim   = commit && PWRITE && hit_trim;
        wr_ctrl   = commit && PWRITE && hit_ctrl;
        wr_unlock = wr_ctrl && (wbyte == CTL_UNLOCK_VALUE);
        wr_select = wr_ctrl && !wbyte[CTL_CEN_BIT];
    end

    // ------------------------------------------------------------
    // Oscillator trim
    // ------------------------------------------------------------
    always_comb begin
        trim_d = trim_q;
        if (wr_trim) begin
            trim_d = wbyte;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            trim_q <= FACTORY_TRIM;
        end else begin
            trim_q <= trim_d;
        end
    end

    // ------------------------------------------------------------
    // Change enable window
    // ------------------------------------------------------------
    always_comb begin
        cen_d     = cen_q;
        cen_cnt_d = cen_cnt_q;
        if (cen_q) begin
            cen_cnt_d = cen_cnt_q + 2'h1;
            if (cen_cnt_q == CEN_WINDOW_LAST) begin
                cen_d = 1'b0;
            end
            if (wr_select) begin
                cen_d = 1'b0;
            end
        end else if (wr_unlock) begin
            cen_d     = 1'b1;
            cen_cnt_d = '0;
        end
        if (!cen_d) begin
            cen_cnt_d = '0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            cen_q     <= 1'b0;
            cen_cnt_q <= '0;
        end else begin
            cen_q     <= cen_d;
            cen_cnt_q <= cen_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Division select
    // ------------------------------------------------------------
    always_comb begin
        sel_rst  = DIV8_FUSE ? SEL_RST_DIV8 : SEL_RST_PLAIN;
        sel_d    = sel_q;
        sel_load = 1'b0;
        if (wr_select && cen_q) begin
            sel_d    = wbyte[CTL_SEL_MSB:0];
            sel_load = 1'b1;
        end
        // reserved codes clamp
        // Reserved codes read back as written but run at the slowest rate.
        sel_to_div = (sel_d > SEL_MAX_LEGAL) ? SEL_MAX_LEGAL : sel_d;
        ctrl_view  = {cen_q, 3'h0, sel_q};
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            sel_q <= sel_rst;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // run-time divided tick
    scpt_divider u_div (
        .clk         (REF_CLK),
        .rst_b       (RST_B),
        .rst_sel     (sel_rst),
        .new_sel     (sel_to_div),
        .new_sel_vld (sel_load),
        .tick        (SYS_CLK_TICK),
        .active_sel  (DIV_SEL_ACTIVE)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // bit 7 is range select
    assign OSC_TRIM = trim_q;
    assign PRDATA   = rdata_q;
    assign PREADY   = (bus_q == SCPT_BUS_WAIT);
    assign PSLVERR  = slverr_q && (bus_q == SCPT_BUS_WAIT);

endmodule : scpt_top

// ---- sim/scpt_top_props.sv ----
// Concurrent checks for the clock prescaler and oscillator trim block.
// Assumes it is bound into scpt_top and sees only that module's ports.
`timescale 1ns/1ps
module scpt_props
    import scpt_pkg::*;
(
    input wire logic              REF_CLK,
    input wire logic              RST_B,
    input wire logic [7:0]        FACTORY_TRIM,
    input wire logic              DIV8_FUSE,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire logic [7:0]        OSC_TRIM,
    input wire logic              SYS_CLK_TICK,
    input wire logic [SEL_W-1:0]  DIV_SEL_ACTIVE
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    // Reset ones stay live during reset, so no disable there
    property p_rst_trim; !RST_B |=> OSC_TRIM == $past(FACTORY_TRIM);
    endproperty
    property p_rst_sel; !RST_B |=> DIV_SEL_ACTIVE ==
        ($past(DIV8_FUSE) ? SEL_RST_DIV8 : SEL_RST_PLAIN); endproperty
    property p_trim_wr; disable iff (!RST_B) PREADY && PWRITE &&
        PADDR == OFS_OSC_TRIM |=> OSC_TRIM == $past(PWDATA[7:0]); endproperty
    property p_trim_rd; disable iff (!RST_B) PREADY && !PWRITE &&
        PADDR == OFS_OSC_TRIM |-> PRDATA == {24'h0, OSC_TRIM}; endproperty
    property p_ctl_rd; disable iff (!RST_B) PREADY && !PWRITE &&
        PADDR == OFS_DIV_CTRL |-> PRDATA[31:8] == 24'h0 &&
        PRDATA[6:4] == 3'h0; endproperty
    property p_sel_legal; disable iff (!RST_B)
        DIV_SEL_ACTIVE <= SEL_MAX_LEGAL; endproperty
    property p_div1; disable iff (!RST_B)
        DIV_SEL_ACTIVE == 4'h0 [*3] |-> SYS_CLK_TICK; endproperty
    // Only judged while the rate stays above factor one
    property p_no_fast; disable iff (!RST_B) SYS_CLK_TICK &&
        DIV_SEL_ACTIVE != 4'h0 ##1 DIV_SEL_ACTIVE != 4'h0 |-> !SYS_CLK_TICK;
    endproperty

    a_rst_trim: assert property (p_rst_trim)
        else $error("trim not loaded at reset");
    a_rst_sel: assert property (p_rst_sel)
        else $error("wrong reset select");
    a_trim_wr: assert property (p_trim_wr)
        else $error("trim write lost");
    a_trim_rd: assert property (p_trim_rd)
        else $error("trim read wrong");
    a_ctl_rd: assert property (p_ctl_rd)
        else $error("unused control bits not zero");
    a_sel_legal: assert property (p_sel_legal)
        else $error("active select above legal");
    a_div1: assert property (p_div1)
        else $error("factor one missed a tick");
    a_no_fast: assert property (p_no_fast)
        else $error("tick came too soon");

    c_unlock: cover property (PREADY && PWRITE && PWDATA[7:0] == 8'h80);
    c_div256: cover property (SYS_CLK_TICK && DIV_SEL_ACTIVE == 4'h8);
    c_slverr: cover property (PREADY && PSLVERR);
endmodule : scpt_props

bind scpt_top scpt_props u_props (.REF_CLK(REF_CLK), .RST_B(RST_B),
    .FACTORY_TRIM(FACTORY_TRIM), .DIV8_FUSE(DIV8_FUSE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OSC_TRIM(OSC_TRIM), .SYS_CLK_TICK(SYS_CLK_TICK),
    .DIV_SEL_ACTIVE(DIV_SEL_ACTIVE));

// ---- sim/scpt_top_tb_top.sv ----
// Self-checking bench for the clock prescaler and trim block.
// Assumes scpt_top with its APB slave; the checker is bound in.
`timescale 1ns/1ps
module scpt_top_tb_top
    import scpt_pkg::*;
;
    logic              clk     = 1'b0;
    logic              rst_b   = 1'b0;
    logic [7:0]        f_trim  = 8'h5a;
    logic              fuse    = 1'b1;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [ADDR_W-1:0] paddr   = '0;
    logic [31:0]       pwdata  = '0;
    logic [31:0]       prdata, rd;
    logic              pready, pslverr, tick, err;
    logic [7:0]        trim;
    logic [SEL_W-1:0]  sel;
    int                error_cnt = 0;
    int                n_tests = 0;
    int                cyc = 0;
    int                n;

    always #10 clk = ~clk;

    scpt_top dut (.REF_CLK(clk), .RST_B(rst_b), .FACTORY_TRIM(f_trim),
        .DIV8_FUSE(fuse), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OSC_TRIM(trim), .SYS_CLK_TICK(tick),
        .DIV_SEL_ACTIVE(sel));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task summarize;
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // Called just after a rising edge; request held until PREADY is seen
    // at a rising edge, then one idle cycle so register updates settle
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task reset(input logic f, input logic [7:0] t);
        @(posedge clk);
        rst_b <= 1'b0;
        fuse <= f;
        f_trim <= t;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask : reset

    task wtick;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 600);
    endtask : wtick

    // Bits 6:4 set on purpose; they must be dropped
    // nothing interleaves the unlock and the select write
    task set_div(input logic [3:0] s);
        apb(OFS_DIV_CTRL, 1'b1, CTL_UNLOCK_VALUE);
        apb(OFS_DIV_CTRL, 1'b1, {4'h7, s});
        apb(OFS_DIV_CTRL, 1'b0, 8'h00);
    endtask : set_div

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize;
        end
    end

    initial begin
        reset(1'b1, 8'h5a);
        chk(trim, 8'h5a);
        chk(sel, SEL_RST_DIV8);
        apb(OFS_DIV_CTRL, 1'b0, 8'h00);
        chk(rd, 32'h3);
        // no nonvolatile writes run, so any trim is allowed
        apb(OFS_OSC_TRIM, 1'b1, 8'h7f);
        apb(OFS_OSC_TRIM, 1'b0, 8'h00);
        chk(rd, 32'h7f);
        apb(OFS_OSC_TRIM, 1'b1, 8'h80);
        chk(trim, 8'h80);
        // Locked select write, then a polluted unlock
        apb(OFS_DIV_CTRL, 1'b1, 8'h05);
        apb(OFS_DIV_CTRL, 1'b1, 8'h81);
        apb(OFS_DIV_CTRL, 1'b1, 8'h05);
        apb(OFS_DIV_CTRL, 1'b0, 8'h00);
        chk(rd, 32'h3);
        // Window reads open, then lapses before the late write
        apb(OFS_DIV_CTRL, 1'b1, CTL_UNLOCK_VALUE);
        apb(OFS_DIV_CTRL, 1'b0, 8'h00);
        chk(rd, 32'h83);
        apb(OFS_DIV_CTRL, 1'b1, 8'h05);
        apb(OFS_DIV_CTRL, 1'b0, 8'h00);
        chk(rd, 32'h3);
        // A second unlock must not stretch the window
        apb(OFS_DIV_CTRL, 1'b1, CTL_UNLOCK_VALUE);
        apb(OFS_DIV_CTRL, 1'b1, CTL_UNLOCK_VALUE);
        apb(OFS_DIV_CTRL, 1'b1, 8'h05);
        apb(OFS_DIV_CTRL, 1'b0, 8'h00);
        chk(rd, 32'h3);
        for (int s = 0; s <= 9; s++) begin
            set_div(s[3:0]);
            chk(rd, s);
            n = 0;
            while (sel !== (s > 8 ? 4'h8 : s[3:0]) && n < 600) begin
                @(posedge clk);
                n++;
            end
            chk(sel, s > 8 ? 32'h8 : s);
            wtick;
            wtick;
            wtick;
            chk(n, s > 8 ? 256 : (1 << s));
        end
        apb(12'h008, 1'b1, 8'hff);
        chk(err, 1'b1);
        apb(12'h008, 1'b0, 8'h00);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(OFS_OSC_TRIM, 1'b0, 8'h00);
        chk(rd, 32'h80);
        reset(1'b0, 8'h33);
        chk(trim, 8'h33);
        chk(sel, SEL_RST_PLAIN);
        set_div(4'h3);
        chk(rd, 32'h3);
        summarize;
    end
endmodule : scpt_top_tb_top
